/* hw/sysref_monitor_pkg.sv */
// ==========================================================================
// Register map, field positions and reset values.
// ==========================================================================
`default_nettype none
package sysref_monitor_pkg;

   // Register offsets, used directly as addresses on the register port.
   localparam logic [8:0] OFS_DET_CLEAR = 9'h102;
   localparam logic [8:0] OFS_TIMING_STATUS = 9'h140;
   localparam logic [8:0] OFS_PIN_FUNCTION = 9'h146;
   localparam logic [8:0] OFS_IRQ_STATUS = 9'h148;
   localparam logic [8:0] OFS_IRQ_MASK = 9'h149;
   localparam logic [8:0] OFS_TEST_PATTERN = 9'h14A;

   // Field positions.
   localparam int DET_CLEAR_BIT = 6;
   localparam int SEEN_FLAG_BIT = 6;
   localparam int SUMMARY_BIT = 5;
   localparam int WINDOW_FLAGS_MSB = 4;
   localparam int PIN_CFG_MSB = 4;
   localparam int IRQ_SEEN_BIT = 0;
   localparam int IRQ_WINDOW_BIT = 1;
   localparam int IRQ_BITS = 2;
   localparam logic [7:0] TEST_PATTERN_MASK = 8'h17;

   // Reset values.
   localparam logic [4:0] WINDOW_FLAGS_RESET = 5'h00;
   localparam logic [4:0] PIN_CFG_RESET = 5'h00;
   localparam logic [7:0] TEST_PATTERN_RESET = 8'h00;
   localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

   // Pin function codes.
   localparam logic [4:0] PINS_SYSREF_A = 5'h00;
   localparam logic [4:0] PINS_POWER_DOWN_ONE = 5'h03;
   localparam logic [4:0] PINS_EXT_REFERENCE = 5'h04;
   localparam logic [4:0] PINS_FREQ_HOP = 5'h05;
   localparam logic [4:0] PINS_SYSREF_B = 5'h08;
   localparam logic [4:0] PINS_OVR_SYSREF = 5'h09;
   localparam logic [4:0] PINS_POWER_DOWN_ZERO = 5'h0A;
   localparam logic [4:0] PINS_OVR_POWER_DOWN = 5'h0B;
   localparam logic [4:0] PINS_OVR_SPLIT = 5'h12;

   // Tap spacing of the delay line ahead of the capture flops, in ps.
   localparam int TAP_FIRST_PS = -60;
   localparam int TAP_STEP_PS = 40;

endpackage
`default_nettype wire

/* hw/sysref_monitor_gpio_mux.sv */
// Notes on behaviour
// - Detection flag sticks until cleared or reset.
// - Summary flag is OR of window flags.
// - Capture on sampling clock falling edge.
// - Flag window when transition within -60/+140ps.
// - Window flags refreshed on each rising edge.
// - First two windows: lead and centre.
// - Last three windows: lagging 20 to 140ps.
// - Pin functions from five-bit code.
// - Codes for SYSREF, power-down, external reference.
// - Codes for hop selects and overrange outputs.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sysref_monitor_gpio_mux #(
   parameter int WINDOWS = 5
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [8:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic IRQ,
   input wire logic [WINDOWS:0] SYSREF_TAPS,
   input wire logic AUX0_IN,
   output logic AUX0_OUT,
   output logic AUX0_OE,
   input wire logic AUX1_IN,
   output logic AUX1_OUT,
   output logic AUX1_OE,
   input wire logic OVR_A,
   input wire logic OVR_B,
   output logic SYSREF_OUT,
   output logic POWER_DOWN,
   output logic EXT_REF_ENABLE,
   output logic [1:0] FREQ_HOP_SELECT
);

   // ======================================================================
   // Elaboration checks
   // ======================================================================
   // The status register holds at most five window flags.
   if (WINDOWS < 1 || WINDOWS > 5) begin : g_bad_windows
      $error("WINDOWS must lie between 1 and 5.");
   end

   // ======================================================================
   // Declarations
   // ======================================================================
   logic [WINDOWS:0] tap_capture;
   logic [WINDOWS:0] tap_meta;
   logic [WINDOWS:0] tap_sync;
   logic last_level;
   logic sysref_rise;
   logic [4:0] window_hit;
   logic [4:0] edge_window_flags;
   logic sysref_seen_flag;
   logic window_flag_summary;
   logic [4:0] pin_cfg;
   logic [7:0] test_pattern;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic aux0_meta;
   logic aux0_sync;
   logic aux1_meta;
   logic aux1_sync;
   logic det_clear;
   logic irq_clear_wr;
   logic [1:0] irq_event;
   logic [7:0] next_rdata;
   logic sysref_on_pin;

   // ======================================================================
   // Capture and synchronisation
   // ======================================================================
   // Each delay-line tap is caught on the falling sampling edge.
   always_ff @(negedge CLOCK) begin
      if (RST) begin
         tap_capture <= '0;
      end else if (CE) begin
         tap_capture <= SYSREF_TAPS;
      end
   end

   // Two flops carry the captured taps into the rising-edge logic.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tap_meta <= '0;
         tap_sync <= '0;
      end else if (CE) begin
         tap_meta <= tap_capture;
         tap_sync <= tap_meta;
      end
   end

   // Pin inputs pass two flops before anything reads them.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         aux0_meta <= 1'b0;
         aux0_sync <= 1'b0;
         aux1_meta <= 1'b0;
         aux1_sync <= 1'b0;
      end else if (CE) begin
         aux0_meta <= AUX0_IN;
         aux0_sync <= aux0_meta;
         aux1_meta <= AUX1_IN;
         aux1_sync <= aux1_meta;
      end
   end

   // ======================================================================
   // Window monitor
   // ======================================================================
   // The reference only reaches the monitor while pin zero carries it.
   assign sysref_on_pin = (pin_cfg == sysref_monitor_pkg::PINS_SYSREF_A)
      || (pin_cfg == sysref_monitor_pkg::PINS_POWER_DOWN_ONE)
      || (pin_cfg == sysref_monitor_pkg::PINS_EXT_REFERENCE)
      || (pin_cfg == sysref_monitor_pkg::PINS_SYSREF_B)
      || (pin_cfg == sysref_monitor_pkg::PINS_OVR_SYSREF);

   // A rising edge is judged at the latest tap.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         last_level <= 1'b0;
      end else if (CE) begin
         last_level <= tap_sync[WINDOWS];
      end
   end

   assign sysref_rise = sysref_on_pin && tap_sync[WINDOWS] && !last_level;

   // Adjacent taps that disagree bracket a transition inside their window.
   for (genvar i = 0; i < 5; i++) begin : g_window
      if (i < WINDOWS) begin : g_used
         assign window_hit[i] = tap_sync[i] ^ tap_sync[i+1];
      end else begin : g_unused
         assign window_hit[i] = 1'b0;
      end
   end

   // Flags are replaced, not accumulated, at every rising edge.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         edge_window_flags <= sysref_monitor_pkg::WINDOW_FLAGS_RESET;
      end else if (CE && sysref_rise) begin
         edge_window_flags <= window_hit;
      end
   end

   assign window_flag_summary = |edge_window_flags;

   // Detection flag: a new edge wins over a clear in the same cycle.
   assign det_clear = WR && (ADDR == sysref_monitor_pkg::OFS_DET_CLEAR)
      && WDATA[sysref_monitor_pkg::DET_CLEAR_BIT];

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         sysref_seen_flag <= 1'b0;
      end else if (CE) begin
         if (sysref_rise) begin
            sysref_seen_flag <= 1'b1;
         end else if (det_clear) begin
            sysref_seen_flag <= 1'b0;
         end
      end
   end

   // ======================================================================
   // Configuration registers
   // ======================================================================
   // Pin code and pattern control; reserved bits are dropped on write.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pin_cfg <= sysref_monitor_pkg::PIN_CFG_RESET;
         test_pattern <= sysref_monitor_pkg::TEST_PATTERN_RESET;
         irq_mask <= sysref_monitor_pkg::IRQ_MASK_RESET;
      end else if (CE && WR) begin
         if (ADDR == sysref_monitor_pkg::OFS_PIN_FUNCTION) begin
            pin_cfg <= WDATA[sysref_monitor_pkg::PIN_CFG_MSB:0];
         end
         if (ADDR == sysref_monitor_pkg::OFS_TEST_PATTERN) begin
            test_pattern <= WDATA & sysref_monitor_pkg::TEST_PATTERN_MASK;
         end
         if (ADDR == sysref_monitor_pkg::OFS_IRQ_MASK) begin
            irq_mask <= WDATA[1:0];
         end
      end
   end

   // ======================================================================
   // Interrupts
   // ======================================================================
   // Events are first detection and any raised window flag.
   assign irq_event[sysref_monitor_pkg::IRQ_SEEN_BIT] = sysref_rise && !sysref_seen_flag;
   assign irq_event[sysref_monitor_pkg::IRQ_WINDOW_BIT] = sysref_rise && (|window_hit);
   assign irq_clear_wr = WR && (ADDR == sysref_monitor_pkg::OFS_IRQ_STATUS);

   // Sticky bits, write one to clear; a new event beats the clear.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         irq_status <= '0;
      end else if (CE) begin
         irq_status <= (irq_status & ~(irq_clear_wr ? WDATA[1:0] : 2'h0)) | irq_event;
      end
   end

   // Level output from a flop.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else if (CE) begin
         IRQ <= |(irq_status & irq_mask);
      end
   end

   // ======================================================================
   // Read port
   // ======================================================================
   // Read data for the addressed register; unmapped reads give zero.
   always_comb begin
      next_rdata = 8'h00;
      case (ADDR)
         sysref_monitor_pkg::OFS_TIMING_STATUS: begin
            next_rdata = {1'b0, sysref_seen_flag, window_flag_summary, edge_window_flags};
         end
         sysref_monitor_pkg::OFS_PIN_FUNCTION: begin
            next_rdata = {3'h0, pin_cfg};
         end
         sysref_monitor_pkg::OFS_IRQ_STATUS: begin
            next_rdata = {6'h00, irq_status};
         end
         sysref_monitor_pkg::OFS_IRQ_MASK: begin
            next_rdata = {6'h00, irq_mask};
         end
         sysref_monitor_pkg::OFS_TEST_PATTERN: begin
            next_rdata = test_pattern;
         end
         default: begin
            next_rdata = 8'h00;
         end
      endcase
   end

   // Data stand for exactly the cycle after the read strobe.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         RDATA <= 8'h00;
      end else if (CE) begin
         RDATA <= RD ? next_rdata : 8'h00;
      end
   end

   // ======================================================================
   // Pin function multiplexer
   // ======================================================================
   // Codes 03, 05, 09, 0A, 0B and 12 drive or listen on the two auxiliary pins.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         AUX0_OUT <= 1'b0;
         AUX0_OE <= 1'b0;
         AUX1_OUT <= 1'b0;
         AUX1_OE <= 1'b0;
         SYSREF_OUT <= 1'b0;
         POWER_DOWN <= 1'b0;
         EXT_REF_ENABLE <= 1'b0;
         FREQ_HOP_SELECT <= 2'h0;
      end else if (CE) begin
         AUX0_OUT <= 1'b0;
         AUX0_OE <= 1'b0;
         AUX1_OUT <= 1'b0;
         AUX1_OE <= 1'b0;
         SYSREF_OUT <= sysref_on_pin && tap_sync[WINDOWS];
         POWER_DOWN <= 1'b0;
         EXT_REF_ENABLE <= 1'b0;
         FREQ_HOP_SELECT <= 2'h0;
         case (pin_cfg)
            sysref_monitor_pkg::PINS_POWER_DOWN_ONE: begin
               POWER_DOWN <= aux1_sync;
            end
            sysref_monitor_pkg::PINS_EXT_REFERENCE: begin
               EXT_REF_ENABLE <= 1'b1;
            end
            sysref_monitor_pkg::PINS_FREQ_HOP: begin
               FREQ_HOP_SELECT <= {aux1_sync, aux0_sync};
            end
            sysref_monitor_pkg::PINS_OVR_SYSREF: begin
               AUX1_OUT <= OVR_A | OVR_B;
               AUX1_OE <= 1'b1;
            end
            sysref_monitor_pkg::PINS_POWER_DOWN_ZERO: begin
               POWER_DOWN <= aux0_sync;
            end
            sysref_monitor_pkg::PINS_OVR_POWER_DOWN: begin
               POWER_DOWN <= aux0_sync;
               AUX1_OUT <= OVR_A | OVR_B;
               AUX1_OE <= 1'b1;
            end
            sysref_monitor_pkg::PINS_OVR_SPLIT: begin
               AUX0_OUT <= OVR_A;
               AUX0_OE <= 1'b1;
               AUX1_OUT <= OVR_B;
               AUX1_OE <= 1'b1;
            end
            default: begin
               AUX0_OE <= 1'b0;
            end
         endcase
      end
   end

   // ======================================================================
   // Assertions
   // ======================================================================
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (RST);

   // The detection flag holds unless cleared.
   det_holds_a: assert property (sysref_seen_flag && !det_clear |=> sysref_seen_flag)
      else $error("Detection flag dropped without a clear.");
   // An edge sets the detection flag at the next edge.
   det_sets_a: assert property (CE && sysref_rise |=> sysref_seen_flag)
      else $error("Edge did not set the detection flag.");
   // A read of the status register shows the summary as OR of flags.
   summary_read_a: assert property (CE && RD && ADDR == sysref_monitor_pkg::OFS_TIMING_STATUS
      |=> RDATA[5] == |RDATA[4:0])
      else $error("Summary bit disagrees with window flags.");
   // Synchronised taps equal the falling-edge capture two cycles back.
   tap_pipe_a: assert property (CE && $past(CE) && $past(CE, 2)
      |-> tap_sync == $past(tap_capture, 2))
      else $error("Tap pipeline out of step.");
   // Flags take the window hits at each edge.
   flags_load_a: assert property (CE && sysref_rise
      |=> edge_window_flags == $past(window_hit))
      else $error("Window flags not refreshed on edge.");
   // Without an edge the flags stand still.
   flags_hold_a: assert property (!(CE && sysref_rise) |=> $stable(edge_window_flags))
      else $error("Window flags changed without an edge.");
   // A transition between the first two taps raises the first flag.
   lead_window_a: assert property (CE && sysref_rise && (tap_sync[0] ^ tap_sync[1])
      |=> edge_window_flags[0])
      else $error("Leading window flag missing.");
   // A transition between the last two taps raises the last flag.
   lag_window_a: assert property (CE && sysref_rise
      && (tap_sync[WINDOWS-1] ^ tap_sync[WINDOWS]) |=> edge_window_flags[WINDOWS-1])
      else $error("Lagging window flag missing.");
   // A pin code write lands in the configuration.
   pin_write_a: assert property (CE && WR && ADDR == sysref_monitor_pkg::OFS_PIN_FUNCTION
      |=> pin_cfg == $past(WDATA[4:0]))
      else $error("Pin code not stored.");
   // Code 00011 passes pin one to the power-down output.
   pin_powerdown_a: assert property (CE && pin_cfg == sysref_monitor_pkg::PINS_POWER_DOWN_ONE
      |=> POWER_DOWN == $past(aux1_sync))
      else $error("Power-down not taken from pin one.");
   // Code 10010 drives both pins.
   pin_overrange_a: assert property (CE && pin_cfg == sysref_monitor_pkg::PINS_OVR_SPLIT
      |=> AUX0_OE && AUX1_OE && AUX0_OUT == $past(OVR_A))
      else $error("Overrange outputs not driven.");
   // Main scenarios.
   edge_seen_c: cover property (CE && sysref_rise ##1 window_flag_summary);
   det_cleared_c: cover property (sysref_seen_flag ##1 det_clear ##1 !sysref_seen_flag);
   split_ovr_c: cover property (pin_cfg == sysref_monitor_pkg::PINS_OVR_SPLIT ##1 AUX0_OE);
   irq_raised_c: cover property (!IRQ ##1 IRQ);

endmodule

`default_nettype wire

/* testbench/sysref_source.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Model of the timing reference source as seen through the delay taps.
module sysref_source #(
   parameter int HIGH_CYCLES = 6
) (
   input wire logic CLOCK,
   input wire logic FIRE,
   input wire logic signed [15:0] OFFSET_PS,
   output logic [5:0] TAPS
);
   // Delay of each tap from the capture instant, in ps.
   localparam int TAP_PS [6] = '{-60, -20, 20, 60, 100, 140};
   int phase = 0;

   // A request gives one cycle of partial edge, a high level, then low again.
   always @(posedge CLOCK) begin
      if (FIRE && phase == 0) begin
         for (int k = 0; k < 6; k++) begin
            TAPS[k] <= (TAP_PS[k] > OFFSET_PS);
         end
         phase <= 1;
      end else if (phase != 0 && phase <= HIGH_CYCLES) begin
         TAPS <= 6'h3F;
         phase <= phase + 1;
      end else begin
         TAPS <= 6'h00;
         phase <= 0;
      end
   end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin errors++; \
   $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
// ==========================================================================
// Bench for the timing monitor and pin function block.
module tb_top;
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic ce = 1'h1;
   logic [8:0] addr = 9'h000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [7:0] rdata;
   logic irq;
   logic [5:0] taps;
   logic a0 = 1'h0;
   logic a1 = 1'h0;
   logic ovr_a = 1'h1;
   logic ovr_b = 1'h0;
   logic o0, e0, o1, e1, sysref_out, power_down, ext_ref;
   logic [1:0] hop;
   logic fire = 1'h0;
   logic signed [15:0] offset_ps = 16'h0000;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;

   sysref_monitor_gpio_mux #(.WINDOWS(5)) i_sysref_monitor_gpio_mux (.CLOCK(clock),
      .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .IRQ(irq), .SYSREF_TAPS(taps), .AUX0_IN(a0), .AUX0_OUT(o0), .AUX0_OE(e0),
      .AUX1_IN(a1), .AUX1_OUT(o1), .AUX1_OE(e1), .OVR_A(ovr_a), .OVR_B(ovr_b),
      .SYSREF_OUT(sysref_out), .POWER_DOWN(power_down), .EXT_REF_ENABLE(ext_ref),
      .FREQ_HOP_SELECT(hop));
   sysref_source i_sysref_source (.CLOCK(clock), .FIRE(fire), .OFFSET_PS(offset_ps),
      .TAPS(taps));

   // Clock of 50 ns period.
   always #25 clock = ~clock;

   // Cuts a hung run short.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         errors++;
         results();
      end
   end

   // ==========================================================================
   // Register port and stimulus tasks.
   task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clock);
      wr <= 1'h0;
   endtask

   task automatic chk_reg(input logic [8:0] a, input logic [7:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'h1;
      @(posedge clock);
      rd <= 1'h0;
      #1;
      `CHECK("read data", e, rdata)
   endtask

   // Sends one reference edge and watches the forwarded level.
   task automatic pulse(input int o, input logic routed);
      logic seen;
      seen = 1'h0;
      @(posedge clock);
      offset_ps <= 16'(o);
      fire <= 1'h1;
      @(posedge clock);
      fire <= 1'h0;
      repeat (14) begin
         @(posedge clock);
         #1 seen |= sysref_out;
      end
      `CHECK("forwarded level", routed, seen)
   endtask

   // Expected {oe0, oe1, out0, out1, power down, ext ref, hop}; overrange follows the pins.
   function automatic logic [7:0] pins_exp(input logic [4:0] c, input logic x0, x1);
      case (c)
         5'h03: pins_exp = {4'h0, x1, 3'h0};
         5'h04: pins_exp = 8'h04;
         5'h05: pins_exp = {6'h00, x1, x0};
         5'h09: pins_exp = 8'h50;
         5'h0A: pins_exp = {4'h0, x0, 3'h0};
         5'h0B: pins_exp = {4'h5, x0, 3'h0};
         5'h12: pins_exp = {2'h3, x0, x1, 4'h0};
         default: pins_exp = 8'h00;
      endcase
   endfunction

   // ==========================================================================
   // Scenarios.
   task automatic t_reset();
      chk_reg(9'h140, 8'h00);
      chk_reg(9'h146, 8'h00);
      chk_reg(9'h14A, 8'h00);
      chk_reg(9'h148, 8'h00);
      chk_reg(9'h149, 8'h00);
      chk_reg(9'h1FF, 8'h00);
      `CHECK("idle outputs", 8'h00, {e0, e1, power_down, ext_ref, hop, irq})
   endtask

   // Window edges, outside values, refresh, then clear of the detection flag.
   task automatic t_windows();
      int offs [7] = '{-60, -20, 20, 60, 139, -61, 140};
      logic [7:0] exp [7] = '{8'h61, 8'h62, 8'h64, 8'h68, 8'h70, 8'h40, 8'h40};
      for (int i = 0; i < 7; i++) begin
         pulse(offs[i], 1'h1);
         chk_reg(9'h140, exp[i]);
      end
      wr_reg(9'h140, 8'hFF);
      chk_reg(9'h140, 8'h40);
      wr_reg(9'h102, 8'h40);
      chk_reg(9'h140, 8'h00);
   endtask

   // Sticky events, masking and write-one-to-clear.
   task automatic t_irq();
      chk_reg(9'h148, 8'h03);
      `CHECK("masked irq", 1'h0, irq)
      wr_reg(9'h149, 8'h02);
      repeat (2) @(posedge clock);
      #1;
      `CHECK("irq raised", 1'h1, irq)
      wr_reg(9'h148, 8'h02);
      repeat (2) @(posedge clock);
      #1;
      `CHECK("irq cleared", 1'h0, irq)
      chk_reg(9'h148, 8'h01);
      wr_reg(9'h148, 8'h01);
      chk_reg(9'h148, 8'h00);
   endtask

   // Every pin code with both input patterns, reserved bits and the clock enable.
   task automatic t_pins();
      logic [4:0] codes [11] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0A, 5'h0B,
         5'h12, 5'h1F, 5'h01};
      for (int i = 0; i < 11; i++) begin
         for (int k = 0; k < 2; k++) begin
            a0 <= (k == 0);
            a1 <= (k == 1);
            ovr_a <= (k == 0);
            ovr_b <= (k == 1);
            wr_reg(9'h146, {3'h0, codes[i]});
            repeat (5) @(posedge clock);
            #1;
            `CHECK("pins", pins_exp(codes[i], a0, a1), {e0, e1, o0 & e0, o1 & e1, power_down,
               ext_ref, hop})
         end
      end
      wr_reg(9'h146, 8'hFF);
      chk_reg(9'h146, 8'h1F);
      wr_reg(9'h14A, 8'hFF);
      chk_reg(9'h14A, 8'h17);
      @(posedge clock);
      ce <= 1'h0;
      wr_reg(9'h146, 8'h05);
      ce <= 1'h1;
      chk_reg(9'h146, 8'h1F);
   endtask

   // Edges reach the monitor only while pin zero carries the reference.
   task automatic t_route();
      logic [4:0] codes [6] = '{5'h12, 5'h0A, 5'h09, 5'h03, 5'h04, 5'h08};
      logic routed;
      for (int i = 0; i < 6; i++) begin
         routed = (i > 1);
         wr_reg(9'h102, 8'h40);
         wr_reg(9'h146, {3'h0, codes[i]});
         pulse(-20, routed);
         chk_reg(9'h140, routed ? 8'h62 : 8'h00);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic results();
      $display("checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Main sequence after a reset of six cycles.
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'h0;
      t_reset();
      t_windows();
      t_irq();
      t_pins();
      t_route();
      results();
   end
endmodule
`default_nettype wire
